// ==== bcs_battery_ctl.sv ====
// battery control status and latch enable registers with apb slave
//
// Notes on behaviour
// - with its latch on, an asserted clock alarm sets status bit 17 until its latch clear is written; zero after reset.
// - with its latch on, an asserted weekly alarm sets status bit 16 until its latch clear is written; zero after reset.
// - status bit 12 set to one bypasses the wake input filters, reset value zero.
// - status bit 11 selects the firmware level as output source while standby power is good, cleared by both resets.
// - status bit 10 is the output level under firmware selection, cleared by both resets.
// - read-only status bit 9 always shows the present output pin level.
// - status bits 6:0 show each wake input latched when its latch is on, else live, after polarity.
// - after reset wake status bits 4 and 5 show latched values, the other wake bits follow the pins, and the output bit shows the hardware circuit level.
// - latch enable bit 17 chooses held or pass-through for the clock alarm, reset value zero.
// - latch enable bit 16 chooses held or pass-through for the weekly alarm.
// - latch enable bits 6:0 choose held or pass-through per wake input, field reset value 30h.
// - a wake input counts as asserted low with polarity bit zero and high with polarity bit one.
// - a one written to a wake latch clear releases the latch unless the input is still asserted.
// - a one written to an alarm latch clear releases the latch unless the alarm is still active.
// - polarity applies after filtering and before the latch.
`timescale 1ns/100ps
`default_nettype none
module bcs_battery_ctl import bcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic system_domain_reset_n,
  input wire logic [BCS_WAKE_N-1:0] wake_input_pin,
  input wire logic [BCS_WAKE_N-1:0] wake_input_polarity,
  input wire logic clock_alarm_in,
  input wire logic weekly_alarm_in,
  input wire logic standby_power_good,
  output logic power_control_output,
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic filt_byp;
    logic fw_sel;
    logic fw_lvl;
    logic [BCS_EVT_N-1:0] latch_en;
    logic [BCS_EVT_N-1:0] irq_stat;
    logic [BCS_EVT_N-1:0] irq_mask;
    logic [BCS_EVT_N-1:0] rd_clr;
    logic [31:0] rdata;
    logic out;
  } bcs_ctl_state_t;

  bcs_ctl_state_t st_q;
  bcs_ctl_state_t st_d;

  bcs_latch_if lk ();

  logic [BCS_WAKE_N-1:0] wake_clean;
  logic [2:0] misc_clean;
  logic [BCS_WAKE_N-1:0] wake_asserted;
  logic [BCS_EVT_N-1:0] eff_evt;
  logic hw_out;
  logic sys_rst;
  logic pg;
  logic setup_ph;
  logic access_wr;
  logic mapped;
  logic [7:0] ofs;

  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  bcs_in_filter #(.W(BCS_WAKE_N), .RST_VAL(BCS_WAKE_IDLE)) u_wake_filt (
    .pclk(pclk),
    .presetn(presetn),
    .bypass(st_q.filt_byp),
    .raw(wake_input_pin),
    .clean(wake_clean)
  );

  // alarms, standby power good and system reset are only synchronised
  bcs_in_filter #(.W(3), .RST_VAL(3'h4)) u_misc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .bypass(1'b1),
    .raw({system_domain_reset_n, standby_power_good, clock_alarm_in ^ 1'b0}),
    .clean(misc_clean)
  );

  logic clk_alarm;
  logic week_alarm;
  logic wk_sync_q;
  logic [2:0] wk_raw_q;

  // weekly alarm: three stages, change counts when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_raw_q <= 3'h0;
      wk_sync_q <= 1'b0;
    end else begin
      wk_raw_q <= {wk_raw_q[1:0], weekly_alarm_in};
      wk_sync_q <= (wk_raw_q[1] == wk_raw_q[2]) ? wk_raw_q[2] : wk_sync_q;
    end
  end

  assign sys_rst = ~misc_clean[2];
  assign pg = misc_clean[1];
  assign clk_alarm = misc_clean[0];
  assign week_alarm = wk_sync_q;

  // polarity applied after filtering, before the latch
  assign wake_asserted = wake_input_polarity ~^ wake_clean;

  // ------------------------------------------------------------
  // latch bank
  // ------------------------------------------------------------
  assign lk.asserted = {clk_alarm, week_alarm, wake_asserted};
  assign lk.enable = st_q.latch_en;

  bcs_event_latch u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.bank)
  );

  // held when latching, straight through otherwise
  assign eff_evt = (st_q.latch_en & lk.held) | (~st_q.latch_en & lk.asserted);

  // hardware circuit: any asserted source powers the rail
  assign hw_out = |eff_evt;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign ofs = paddr[7:0];
  assign setup_ph = psel & ~penable;
  assign access_wr = psel & penable & pwrite & mapped;

  function automatic logic is_mapped(input logic [31:0] a);
    logic [7:0] o;
    o = a[7:0];
    is_mapped = (a[31:8] == 24'h000000) && ((o == BCS_OFS_STATUS) || (o == BCS_OFS_LATCH_EN) ||
                (o == BCS_OFS_LATCH_CLR) || (o == BCS_OFS_IRQ_STAT) ||
                (o == BCS_OFS_IRQ_MASK));
  endfunction

  function automatic logic [31:0] evt_word(input logic [BCS_EVT_N-1:0] v);
    evt_word = '0;
    evt_word[BCS_WAKE_N-1:0] = v[BCS_WAKE_N-1:0];
    evt_word[BCS_BIT_WEEK_ALARM] = v[BCS_EV_WEEK];
    evt_word[BCS_BIT_CLK_ALARM] = v[BCS_EV_CLK];
  endfunction

  function automatic logic [BCS_EVT_N-1:0] word_evt(input logic [31:0] w);
    word_evt = {w[BCS_BIT_CLK_ALARM], w[BCS_BIT_WEEK_ALARM], w[BCS_WAKE_N-1:0]};
  endfunction

  assign mapped = is_mapped(paddr);

  // status word; reserved bits stay zero
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    // alarm bits show only a latched capture, never the live alarm
    status_word[BCS_BIT_CLK_ALARM] = st_q.latch_en[BCS_EV_CLK] & lk.held[BCS_EV_CLK];
    status_word[BCS_BIT_WEEK_ALARM] = st_q.latch_en[BCS_EV_WEEK] & lk.held[BCS_EV_WEEK];
    status_word[BCS_BIT_FILT_BYP] = st_q.filt_byp;
    status_word[BCS_BIT_FW_SEL] = st_q.fw_sel;
    status_word[BCS_BIT_FW_LVL] = st_q.fw_lvl;
    status_word[BCS_BIT_OUT] = st_q.out;
    // active-low view: one means not asserted
    status_word[BCS_WAKE_N-1:0] = ~eff_evt[BCS_WAKE_N-1:0];
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    lk.clear = '0;
    // read data captured in setup phase
    if (setup_ph && !pwrite) begin
      st_d.rd_clr = '0;
      case (ofs)
        BCS_OFS_STATUS: st_d.rdata = status_word;
        BCS_OFS_LATCH_EN: st_d.rdata = evt_word(st_q.latch_en);
        BCS_OFS_IRQ_STAT: begin
          st_d.rdata = evt_word(st_q.irq_stat);
          st_d.rd_clr = st_q.irq_stat;
        end
        BCS_OFS_IRQ_MASK: st_d.rdata = evt_word(st_q.irq_mask);
        default: st_d.rdata = '0;
      endcase
      if (!mapped) begin
        st_d.rdata = '0;
        st_d.rd_clr = '0;
      end
    end
    // read of interrupt status clears only what was returned
    if (psel && penable && !pwrite && mapped && ofs == BCS_OFS_IRQ_STAT) begin
      st_d.irq_stat = st_q.irq_stat & ~st_q.rd_clr;
      st_d.rd_clr = '0;
    end
    if (access_wr) begin
      case (ofs)
        BCS_OFS_STATUS: begin
          if (pstrb[1]) begin
            st_d.filt_byp = pwdata[BCS_BIT_FILT_BYP];
            st_d.fw_sel = pwdata[BCS_BIT_FW_SEL];
            st_d.fw_lvl = pwdata[BCS_BIT_FW_LVL];
          end
        end
        BCS_OFS_LATCH_EN: begin
          if (pstrb[0]) begin
            st_d.latch_en[BCS_WAKE_N-1:0] = pwdata[BCS_WAKE_N-1:0];
          end
          if (pstrb[2]) begin
            st_d.latch_en[BCS_EV_WEEK] = pwdata[BCS_BIT_WEEK_ALARM];
            st_d.latch_en[BCS_EV_CLK] = pwdata[BCS_BIT_CLK_ALARM];
          end
        end
        BCS_OFS_LATCH_CLR: begin
          lk.clear[BCS_WAKE_N-1:0] = pstrb[0] ? pwdata[BCS_WAKE_N-1:0] : '0;
          lk.clear[BCS_EV_WEEK] = pstrb[2] & pwdata[BCS_BIT_WEEK_ALARM];
          lk.clear[BCS_EV_CLK] = pstrb[2] & pwdata[BCS_BIT_CLK_ALARM];
        end
        BCS_OFS_IRQ_MASK: begin
          st_d.irq_mask = word_evt(pwdata);
        end
        default: begin
        end
      endcase
    end
    // system reset clears firmware control bits only
    if (sys_rst) begin
      st_d.fw_sel = 1'b0;
      st_d.fw_lvl = 1'b0;
    end
    // new latch assertions are sticky interrupt events; set wins over clear
    st_d.irq_stat = st_d.irq_stat | lk.set_evt;
    // firmware level drives the pin only with standby power good
    st_d.out = (pg && st_q.fw_sel) ? st_q.fw_lvl : hw_out;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{filt_byp: 1'b0, fw_sel: 1'b0, fw_lvl: 1'b0, latch_en: BCS_LATCH_EN_RST,
                irq_stat: '0, irq_mask: BCS_IRQ_MASK_RST, rd_clr: '0, rdata: '0,
                out: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign power_control_output = st_q.out;
  assign irq = |(st_q.irq_stat & st_q.irq_mask);

endmodule
`default_nettype wire

// ==== bcs_battery_ctl_asserts.sv ====
// assertion checker for the battery control status block
`timescale 1ns/100ps
`default_nettype none
module bcs_battery_ctl_asserts import bcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic system_domain_reset_n,
  input wire logic standby_power_good,
  input wire logic power_control_output,
  input wire logic irq
);
  // ------
  // shadow of the firmware output bits
  // ------
  logic [1:0] fw_q, fw_d;
  logic [3:0] cnt_q, cnt_d;
  wire logic hit = paddr inside {32'h0, 32'h4, 32'h8, 32'h24, 32'h28};
  wire logic wst = psel && penable && pwrite && paddr == 32'h0 && pstrb[1];
  wire logic calm = !wst && standby_power_good && system_domain_reset_n;
  always_comb begin
    fw_d = wst ? pwdata[11:10] : fw_q;
    if (!system_domain_reset_n) begin
      fw_d = 2'h0;
    end
    cnt_d = calm ? cnt_q + 4'(cnt_q != 4'hf) : 4'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_q <= 2'h0;
      cnt_q <= 4'h0;
    end else begin
      fw_q <= fw_d;
      cnt_q <= cnt_d;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [31:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence s_acc;
    psel && penable;
  endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (s_acc |-> (hit || pslverr)) else $error("no slave error");
  a_mapped_noerr: assert property (s_acc |-> (!hit || !pslverr)) else $error("bad slave error");
  a_unmapped_zero: assert property (s_acc |-> (hit || pwrite || prdata == 32'h0))
    else $error("unmapped read data");
  a_status_rsvd: assert property (s_rd(32'h0) |-> (prdata & 32'hfffce180) == 32'h0)
    else $error("status reserved bits set");
  a_latch_rsvd: assert property (s_rd(32'h4) |-> (prdata & 32'hfffcff80) == 32'h0)
    else $error("latch enable reserved bits set");
  a_clear_reads_zero: assert property (s_rd(32'h8) |-> prdata == 32'h0)
    else $error("latch clear read data");
  a_out_mirror: assert property (s_rd(32'h0) |-> prdata[9] == $past(power_control_output))
    else $error("output status bit differs");
  a_fw_drive: assert property (cnt_q >= 4'h8 && fw_q[1] |-> power_control_output == fw_q[0])
    else $error("firmware output level");
  a_irq_idle: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
endmodule
bind bcs_battery_ctl bcs_battery_ctl_asserts bcs_battery_ctl_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .system_domain_reset_n(system_domain_reset_n),
  .standby_power_good(standby_power_good), .power_control_output(power_control_output),
  .irq(irq));
`default_nettype wire

// ==== bcs_event_latch.sv ====
// bank of event latches, assertion wins over clear
`timescale 1ns/100ps
`default_nettype none
module bcs_event_latch import bcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  bcs_latch_if.bank lk
);

  typedef struct packed {
    logic [BCS_EVT_N-1:0] held;
  } bcs_latch_state_t;

  bcs_latch_state_t st_q;
  bcs_latch_state_t st_d;

  always_comb begin
    st_d = st_q;
    // live assertion overrides a clear in the same cycle
    st_d.held = lk.enable & ((st_q.held & ~lk.clear) | lk.asserted);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lk.held = st_q.held;
  assign lk.set_evt = lk.asserted & lk.enable & ~st_q.held;

endmodule
`default_nettype wire

// ==== bcs_far_side.sv ====
// far side model: buttons, alarm sources and regulator
`timescale 1ns/100ps
`default_nettype none
module bcs_far_side import bcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [BCS_WAKE_N-1:0] press,
  input wire logic [BCS_WAKE_N-1:0] pol,
  input wire logic [1:0] alarm,
  input wire logic ext_rail,
  input wire logic power_control_output,
  output logic [BCS_WAKE_N-1:0] wake_input_pin,
  output logic clock_alarm_in,
  output logic weekly_alarm_in,
  output logic standby_power_good
);
  logic [2:0] ramp_q;
  // button drives its active level only while pressed
  assign wake_input_pin = ~(press ^ pol);
  assign clock_alarm_in = alarm[1];
  assign weekly_alarm_in = alarm[0];
  // rail ramps up for seven cycles, drops at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= 3'h0;
    end else if (!(ext_rail || power_control_output)) begin
      ramp_q <= 3'h0;
    end else if (ramp_q != 3'h7) begin
      ramp_q <= ramp_q + 3'h1;
    end
  end
  assign standby_power_good = ramp_q == 3'h7;
endmodule
`default_nettype wire

// ==== bcs_in_filter.sv ====
// pin synchroniser with optional glitch filter
`timescale 1ns/100ps
`default_nettype none
module bcs_in_filter import bcs_pkg::*; #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bypass,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
    logic [W-1:0] out;
    logic [W-1:0][5:0] cnt;
  } bcs_filt_state_t;

  bcs_filt_state_t st_q;
  bcs_filt_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      // a change counts once second and third stage agree
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.stable[i] = st_q.s3[i];
      end
      if (bypass) begin
        st_d.out[i] = st_q.stable[i];
        st_d.cnt[i] = '0;
      end else if (st_q.stable[i] == st_q.out[i]) begin
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == BCS_FILT_LAST) begin
        st_d.out[i] = st_q.stable[i];
        st_d.cnt[i] = '0;
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL, out: RST_VAL,
                cnt: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign clean = st_q.out;

endmodule
`default_nettype wire

// ==== bcs_latch_if.sv ====
// signals between the register logic and the event latch bank
`timescale 1ns/100ps
`default_nettype none
interface bcs_latch_if;
  import bcs_pkg::*;
  logic [BCS_EVT_N-1:0] asserted;
  logic [BCS_EVT_N-1:0] enable;
  logic [BCS_EVT_N-1:0] clear;
  logic [BCS_EVT_N-1:0] held;
  logic [BCS_EVT_N-1:0] set_evt;
  modport ctrl (output asserted, output enable, output clear, input held, input set_evt);
  modport bank (input asserted, input enable, input clear, output held, output set_evt);
endinterface
`default_nettype wire

// ==== bcs_pkg.sv ====
// constants and types shared by the battery control status block
package bcs_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] BCS_OFS_STATUS = 8'h00;
  localparam logic [7:0] BCS_OFS_LATCH_EN = 8'h04;
  localparam logic [7:0] BCS_OFS_LATCH_CLR = 8'h08;
  localparam logic [7:0] BCS_OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] BCS_OFS_IRQ_MASK = 8'h28;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BCS_WAKE_N = 7;
  localparam int BCS_EVT_N = 9;
  localparam int BCS_BIT_CLK_ALARM = 17;
  localparam int BCS_BIT_WEEK_ALARM = 16;
  localparam int BCS_BIT_FILT_BYP = 12;
  localparam int BCS_BIT_FW_SEL = 11;
  localparam int BCS_BIT_FW_LVL = 10;
  localparam int BCS_BIT_OUT = 9;
  // event vector: [6:0] wake inputs, [7] weekly alarm, [8] clock alarm
  localparam int BCS_EV_WEEK = 7;
  localparam int BCS_EV_CLK = 8;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [8:0] BCS_LATCH_EN_RST = 9'h030;
  localparam logic [8:0] BCS_IRQ_MASK_RST = 9'h000;
  localparam logic [6:0] BCS_WAKE_IDLE = 7'h7f;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int BCS_CLK_PERIOD_NS = 40;
  localparam int BCS_FILT_TIME_NS = 1000;
  localparam int BCS_FILT_CYCLES = (BCS_FILT_TIME_NS + BCS_CLK_PERIOD_NS - 1) / BCS_CLK_PERIOD_NS;
  localparam logic [5:0] BCS_FILT_LAST = 6'(BCS_FILT_CYCLES - 1);

endpackage

// ==== testbench.sv ====
// self-checking testbench for the battery control status block
`timescale 1ns/100ps
`default_nettype none
module testbench import bcs_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sysrst_n = 1'b1, rail = 1'b0, pready, pslverr, out, irq, calm, walm, pg, rerr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'hf;
  logic [6:0] press = 7'h0, pol, pin;
  logic [1:0] alarm = 2'h0;
  int n_errors = 0, cmp_count = 0, cyc = 0, i, k;
  bcs_battery_ctl bcs_battery_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .system_domain_reset_n(sysrst_n),
    .wake_input_pin(pin), .wake_input_polarity(pol), .clock_alarm_in(calm),
    .weekly_alarm_in(walm), .standby_power_good(pg), .power_control_output(out), .irq(irq));
  bcs_far_side bcs_far_side_inst (.pclk(pclk), .presetn(presetn), .press(press), .pol(pol),
    .alarm(alarm), .ext_rail(rail), .power_control_output(out), .wake_input_pin(pin),
    .clock_alarm_in(calm), .weekly_alarm_in(walm), .standby_power_good(pg));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  // ------
  // tasks
  // ------
  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // status word from asserted events and {bypass, select, level, output}
  function automatic logic [31:0] st(input logic [8:0] ev, input logic [3:0] ctl);
    return {14'h0, ev[8:7], 3'h0, ctl, 2'h0, ~ev[6:0]};
  endfunction
  // ------
  // sequence
  // ------
  initial begin
    void'($urandom(32'h4aacbfaa));
    pol <= {3'h0, 4'($urandom)};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(8'h00, st(9'h0, 4'h0));
    rd(8'h04, 32'h30);
    rd(8'h0c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h3007f);
    wr(8'h00, 32'hfffff7ff);
    rd(8'h00, st(9'h0, 4'ha));
    rail <= 1'b1;
    wr(8'h00, 32'h1c00);
    repeat (16) @(posedge pclk);
    chk({31'h0, out}, 32'h1);
    rd(8'h00, st(9'h0, 4'hf));
    wr(8'h00, 32'h1800);
    repeat (4) @(posedge pclk);
    chk({31'h0, out}, 32'h0);
    wr(8'h00, 32'h1c00);
    sysrst_n <= 1'b0;
    repeat (8) @(posedge pclk);
    sysrst_n <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(8'h00, st(9'h0, 4'h8));
    wr(8'h00, 32'h0);
    rail <= 1'b0;
    wr(8'h28, 32'h3007f);
    for (k = 0; k < 6; k++) begin
      i = $urandom_range(6, 0);
      wr(8'h04, {14'h0, 2'h3, 9'h0, {7{k[0]}}});
      press[i] <= 1'b1;
      repeat (40) @(posedge pclk);
      chk({31'h0, out}, 32'h1);
      wr(8'h08, 32'h1 << i);
      rd(8'h00, st(9'h1 << i, 4'h1));
      press[i] <= 1'b0;
      repeat (40) @(posedge pclk);
      rd(8'h00, st(k[0] ? 9'h1 << i : 9'h0, {3'h0, k[0]}));
      chk({31'h0, irq}, {31'h0, k[0]});
      rd(8'h24, k[0] ? 32'h1 << i : 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h08, 32'h1 << i);
      repeat (4) @(posedge pclk);
      rd(8'h00, st(9'h0, 4'h0));
    end
    wr(8'h28, 32'h7f);
    for (k = 0; k < 2; k++) begin
      alarm[k] <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(8'h08, 32'h10000 << k);
      rd(8'h00, st(9'h80 << k, 4'h1));
      alarm[k] <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(8'h00, st(9'h80 << k, 4'h1));
      rd(8'h24, 32'h10000 << k);
      wr(8'h08, 32'h10000 << k);
      repeat (4) @(posedge pclk);
      rd(8'h00, st(9'h0, 4'h0));
    end
    wr(8'h04, 32'h0);
    alarm <= 2'h3;
    repeat (8) @(posedge pclk);
    rd(8'h00, st(9'h0, 4'h1));
    alarm <= 2'h0;
    repeat (8) @(posedge pclk);
    chk({31'h0, out}, 32'h0);
    wr(8'h00, 32'h1000);
    press[6] <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(8'h00, st(9'h40, 4'h9));
    press[6] <= 1'b0;
    repeat (4) @(posedge pclk);
    conclude();
  end
endmodule
`default_nettype wire
